/* File: rtl/bkan_pkg.sv */
// holds the register map, field positions and reset values of the
// backplane negotiation status and page registers.
// assumes a 32-bit apb with byte addresses; word index times four.
package bkan_pkg;
    localparam int BKAN_ADDR_W = 16;
    localparam int BKAN_DATA_W = 32;
    localparam int BKAN_PAGE_W = 50;

    // ---------------------------------------------------------------
    // word indexes and byte addresses
    // ---------------------------------------------------------------
    localparam logic [BKAN_ADDR_W-1:0] BKAN_IDX_CONTROL = 16'h04c0;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_IDX_STATUS = 16'h04c2;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_IDX_PAGE_LOW = 16'h04c3;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_IDX_PAGE_HIGH = 16'h04c4;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_ADDR_CONTROL = BKAN_IDX_CONTROL << 2;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_ADDR_STATUS = BKAN_IDX_STATUS << 2;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_ADDR_PAGE_LOW = BKAN_IDX_PAGE_LOW << 2;
    localparam logic [BKAN_ADDR_W-1:0] BKAN_ADDR_PAGE_HIGH = BKAN_IDX_PAGE_HIGH << 2;

    // ---------------------------------------------------------------
    // control word fields
    // ---------------------------------------------------------------
    localparam int BKAN_CTL_BASE_PAGE = 1;
    localparam int BKAN_CTL_OVERRIDE = 5;

    // ---------------------------------------------------------------
    // status word fields
    // ---------------------------------------------------------------
    localparam int BKAN_ST_PAGE_RX = 1;
    localparam int BKAN_ST_COMPLETE = 2;
    localparam int BKAN_ST_RF_SENT = 3;
    localparam int BKAN_ST_RX_IDLE = 4;
    localparam int BKAN_ST_ABILITY = 5;
    localparam int BKAN_ST_LINK_UP = 6;
    localparam int BKAN_ST_LP_ABILITY = 7;
    localparam int BKAN_ST_FEC = 8;
    localparam int BKAN_ST_SEQ_FAIL = 9;
    localparam int BKAN_ST_READY_LO = 12;
    localparam int BKAN_READY_W = 6;
    // sticky flag slots inside the clear-on-read bank
    localparam int BKAN_FLAG_PAGE = 0;
    localparam int BKAN_FLAG_RF = 1;
    localparam int BKAN_FLAG_LINK = 2;
    localparam int BKAN_FLAG_W = 3;

    // ---------------------------------------------------------------
    // base page low / override fields
    // ---------------------------------------------------------------
    localparam int BKAN_LOW_W = 16;
    localparam int BKAN_TECH_LO = 16;
    localparam int BKAN_TECH_W = 6;
    localparam int BKAN_FEC_LO = 24;
    localparam int BKAN_FEC_W = 2;
    localparam int BKAN_PAUSE_LO = 28;
    localparam int BKAN_PAUSE_W = 3;
    localparam logic [BKAN_DATA_W-1:0] BKAN_LOW_MASK = 32'h733f_ffff;
    localparam logic [BKAN_DATA_W-1:0] BKAN_HIGH_MASK = 32'h3fff_ffff;
    localparam logic [BKAN_DATA_W-1:0] BKAN_CTL_MASK = 32'h0000_0022;
    localparam logic [BKAN_DATA_W-1:0] BKAN_REG_RESET = 32'h0000_0000;

    // ---------------------------------------------------------------
    // transmitted page layout
    // ---------------------------------------------------------------
    localparam int BKAN_PG_ECHO_LO = 5;
    localparam int BKAN_PG_ECHO_W = 5;
    localparam int BKAN_PG_ACK = 14;
    localparam int BKAN_PG_NONCE_LO = 16;
    localparam int BKAN_HI_NONCE_W = 5;
    localparam int BKAN_PG_TECH_LO = 21;
    localparam int BKAN_HI_TECH_W = 25;
    localparam int BKAN_PG_PRBS = 49;
endpackage : bkan_pkg

/* File: rtl/bkan_cor_flags.sv */
// holds a bank of sticky clear-on-read status flags.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module bkan_cor_flags
#(
    parameter int WIDTH = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flag_q
);
    // ---------------------------------------------------------------
    // one sticky bit per flag
    // ---------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_flag
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                flag_q[i] <= 1'b0;
            else if (set_i[i])
                flag_q[i] <= 1'b1;
            else if (clr_i[i])
                flag_q[i] <= 1'b0;
        end
    end
endmodule : bkan_cor_flags

/* File: rtl/bkan_page_build.sv */
// builds the next base page for the transmit negotiation machine.
// assumes the machine supplies its own page, ack, echoed nonce and prbs.
`timescale 1ns/1ps
module bkan_page_build
    import bkan_pkg::*;
(
    input wire logic user_en,
    input wire logic [BKAN_DATA_W-1:0] user_low,
    input wire logic [BKAN_DATA_W-1:0] user_high,
    input wire logic [BKAN_PAGE_W-1:0] sm_page,
    input wire logic sm_ack,
    input wire logic [BKAN_PG_ECHO_W-1:0] sm_echo_nonce,
    input wire logic sm_prbs,
    output logic [BKAN_PAGE_W-1:0] page_d
);
    logic [BKAN_PAGE_W-1:0] user_page;

    always_comb
    begin
        user_page = sm_page;
        // user low bits from the register; ack and echo stay with the machine
        user_page[BKAN_LOW_W-1:0] = user_low[BKAN_LOW_W-1:0];
        user_page[BKAN_PG_ACK] = sm_ack;
        user_page[BKAN_PG_ECHO_LO +: BKAN_PG_ECHO_W] = sm_echo_nonce;
        // high word carries nonce and technology ability
        user_page[BKAN_PG_NONCE_LO +: BKAN_HI_NONCE_W] = user_high[BKAN_HI_NONCE_W-1:0];
        user_page[BKAN_PG_TECH_LO +: BKAN_HI_TECH_W] =
            user_high[BKAN_HI_NONCE_W +: BKAN_HI_TECH_W];
        // user page only while the base-page control bit is set
        page_d = user_en ? user_page : sm_page;
        // prbs bit always from the machine
        page_d[BKAN_PG_PRBS] = sm_prbs;
    end
endmodule : bkan_page_build

/* File: rtl/bkan_status_pages.sv */
// holds the apb register bank for backplane negotiation status,
// user base pages and advertised parameter overrides.
// assumes the negotiation engine runs on pclk and drives the event
// and level inputs synchronously; no synchronisers are needed.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - status bit 1 flags a received page; cleared by reading status.
// - status bit 2 shows negotiation complete, zero while in progress.
// - status bit 3 flags fault sent to partner; cleared by reading.
// - status bit 4 shows receive machine idle on incompatible data.
// - status bit 5 reports negotiation ability, constant one here.
// - status bit 6 latches link up; cleared by reading status once link is down.
// - status bit 7 shows the partner can negotiate.
// - status bit 8 shows fec resolved in use.
// - status bit 9 shows a sequencer negotiation failure.
// - status bits 17:12 give one-hot link ready per technology.
// - user low bits sent; ack and echoed nonce from machine.
// - page bit 49 (prbs) always generated by the machine.
// - override bits 21:16 replace the advertised technology set.
// - override bits 25:24 replace the advertised fec bits.
// - override bits 30:28 replace the advertised pause bits.
// - overrides act only while the override-enable bit is set.
// - user high 29:5 to page 45:21, 4:0 to page 20:16.
// - base-page bit selects user pages, else machine-built pages.
module bkan_status_pages
    import bkan_pkg::*;
#(
    parameter logic [BKAN_TECH_W-1:0] DEF_TECH = 6'h04,
    parameter logic [BKAN_FEC_W-1:0] DEF_FEC = 2'h0,
    parameter logic [BKAN_PAUSE_W-1:0] DEF_PAUSE = 3'h0,
    parameter bit AN_ABILITY = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [BKAN_ADDR_W-1:0] paddr,
    input wire logic [BKAN_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [BKAN_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic page_rx_evt,
    input wire logic an_complete,
    input wire logic rf_sent_evt,
    input wire logic rx_idle,
    input wire logic link_up,
    input wire logic lp_an_ability,
    input wire logic fec_negotiated,
    input wire logic seq_failure,
    input wire logic [BKAN_READY_W-1:0] link_ready,
    input wire logic [BKAN_PAGE_W-1:0] sm_page,
    input wire logic sm_ack,
    input wire logic [BKAN_PG_ECHO_W-1:0] sm_echo_nonce,
    input wire logic sm_prbs,
    output logic [BKAN_PAGE_W-1:0] tx_page,
    output logic user_base_page_en,
    output logic override_en,
    output logic [BKAN_TECH_W-1:0] advertised_technology_set,
    output logic [BKAN_FEC_W-1:0] advertised_fec_bits,
    output logic [BKAN_PAUSE_W-1:0] advertised_pause_bits
);
    // ---------------------------------------------------------------
    // apb handshake
    // ---------------------------------------------------------------
    // one wait state keeps pready and prdata registered
    logic pready_q;
    logic pslverr_q;
    logic [BKAN_DATA_W-1:0] prdata_q;
    logic [BKAN_DATA_W-1:0] rd_data;
    wire access = psel & penable;
    wire first_acc = access & ~pready_q;
    wire done = access & pready_q;
    wire hit_ctl = (paddr == BKAN_ADDR_CONTROL);
    wire hit_st = (paddr == BKAN_ADDR_STATUS);
    wire hit_low = (paddr == BKAN_ADDR_PAGE_LOW);
    wire hit_high = (paddr == BKAN_ADDR_PAGE_HIGH);
    wire mapped = hit_ctl | hit_st | hit_low | hit_high;
    wire wr_done = done & pwrite & mapped;
    wire st_read_done = done & ~pwrite & hit_st;
    wire [BKAN_DATA_W-1:0] byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
        {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_q <= 1'b0;
        else
            pready_q <= first_acc;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= BKAN_REG_RESET;
            pslverr_q <= 1'b0;
        end
        else if (first_acc)
        begin
            prdata_q <= pwrite ? BKAN_REG_RESET : rd_data;
            pslverr_q <= ~mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ---------------------------------------------------------------
    // writable registers
    // ---------------------------------------------------------------
    logic [BKAN_DATA_W-1:0] ctl_q;
    logic [BKAN_DATA_W-1:0] low_q;
    logic [BKAN_DATA_W-1:0] high_q;
    wire [BKAN_DATA_W-1:0] ctl_d = (ctl_q & ~byte_mask) | (pwdata & byte_mask);
    wire [BKAN_DATA_W-1:0] low_d = (low_q & ~byte_mask) | (pwdata & byte_mask);
    wire [BKAN_DATA_W-1:0] high_d = (high_q & ~byte_mask) | (pwdata & byte_mask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q <= BKAN_REG_RESET;
            low_q <= BKAN_REG_RESET;
            high_q <= BKAN_REG_RESET;
        end
        else if (wr_done)
        begin
            if (hit_ctl)
                ctl_q <= ctl_d & BKAN_CTL_MASK;
            if (hit_low)
                low_q <= low_d & BKAN_LOW_MASK;
            if (hit_high)
                high_q <= high_d & BKAN_HIGH_MASK;
        end
    end

    // ---------------------------------------------------------------
    // clear-on-read status flags
    // ---------------------------------------------------------------
    logic [BKAN_FLAG_W-1:0] flag_q;
    logic [BKAN_FLAG_W-1:0] snap_q;
    logic [BKAN_FLAG_W-1:0] flag_set;
    logic [BKAN_FLAG_W-1:0] flag_clr;

    assign flag_set[BKAN_FLAG_PAGE] = page_rx_evt;
    assign flag_set[BKAN_FLAG_RF] = rf_sent_evt;
    // held while link is up, latched until read
    assign flag_set[BKAN_FLAG_LINK] = link_up;
    // clear only what the reader actually saw as one
    assign flag_clr = st_read_done ? snap_q : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            snap_q <= '0;
        else if (first_acc)
            snap_q <= (hit_st & ~pwrite) ? flag_q : '0;
    end

    bkan_cor_flags #(
        .WIDTH(BKAN_FLAG_W)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flag_q(flag_q)
    );

    // ---------------------------------------------------------------
    // status word and read mux
    // ---------------------------------------------------------------
    logic [BKAN_DATA_W-1:0] status_word;

    always_comb
    begin
        status_word = '0;
        status_word[BKAN_ST_PAGE_RX] = flag_q[BKAN_FLAG_PAGE];
        status_word[BKAN_ST_COMPLETE] = an_complete;
        status_word[BKAN_ST_RF_SENT] = flag_q[BKAN_FLAG_RF];
        status_word[BKAN_ST_RX_IDLE] = rx_idle;
        status_word[BKAN_ST_ABILITY] = AN_ABILITY;
        status_word[BKAN_ST_LINK_UP] = flag_q[BKAN_FLAG_LINK];
        status_word[BKAN_ST_LP_ABILITY] = lp_an_ability;
        status_word[BKAN_ST_FEC] = fec_negotiated;
        status_word[BKAN_ST_SEQ_FAIL] = seq_failure;
        status_word[BKAN_ST_READY_LO +: BKAN_READY_W] = link_ready;
    end

    assign rd_data = hit_st ? status_word :
                     hit_ctl ? ctl_q :
                     hit_low ? low_q :
                     hit_high ? high_q : BKAN_REG_RESET;

    // ---------------------------------------------------------------
    // advertised parameters and transmit page
    // ---------------------------------------------------------------
    // overrides reach the advertised outputs through registers one pclk after the control bit changes
    logic [BKAN_PAGE_W-1:0] tx_page_q;
    logic [BKAN_PAGE_W-1:0] page_d;
    logic ovr_q;
    logic user_en_q;
    logic [BKAN_TECH_W-1:0] tech_q;
    logic [BKAN_FEC_W-1:0] fec_q;
    logic [BKAN_PAUSE_W-1:0] pause_q;
    wire ovr = ctl_q[BKAN_CTL_OVERRIDE];
    // fields ignored unless override is enabled
    wire [BKAN_TECH_W-1:0] tech_d = ovr ? low_q[BKAN_TECH_LO +: BKAN_TECH_W] : DEF_TECH;
    wire [BKAN_FEC_W-1:0] fec_d = ovr ? low_q[BKAN_FEC_LO +: BKAN_FEC_W] : DEF_FEC;
    wire [BKAN_PAUSE_W-1:0] pause_d =
        ovr ? low_q[BKAN_PAUSE_LO +: BKAN_PAUSE_W] : DEF_PAUSE;

    bkan_page_build u_page (
        .user_en(ctl_q[BKAN_CTL_BASE_PAGE]),
        .user_low(low_q),
        .user_high(high_q),
        .sm_page(sm_page),
        .sm_ack(sm_ack),
        .sm_echo_nonce(sm_echo_nonce),
        .sm_prbs(sm_prbs),
        .page_d(page_d)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_page_q <= '0;
            ovr_q <= 1'b0;
            user_en_q <= 1'b0;
            tech_q <= '0;
            fec_q <= '0;
            pause_q <= '0;
        end
        else
        begin
            tx_page_q <= page_d;
            ovr_q <= ovr;
            user_en_q <= ctl_q[BKAN_CTL_BASE_PAGE];
            tech_q <= tech_d;
            fec_q <= fec_d;
            pause_q <= pause_d;
        end
    end

    assign tx_page = tx_page_q;
    assign override_en = ovr_q;
    assign user_base_page_en = user_en_q;
    assign advertised_technology_set = tech_q;
    assign advertised_fec_bits = fec_q;
    assign advertised_pause_bits = pause_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    page_flag_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        page_rx_evt |=> flag_q[BKAN_FLAG_PAGE])
        else $error("page received flag not set after event");

    cor_read_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (first_acc && hit_st && !pwrite && flag_q[BKAN_FLAG_RF]) ##1
        (done && !rf_sent_evt) |=> !flag_q[BKAN_FLAG_RF])
        else $error("fault sent flag not cleared by status read");

    read_sees_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (first_acc && hit_st && !pwrite && flag_q[BKAN_FLAG_RF])
        |=> prdata[BKAN_ST_RF_SENT] && pready)
        else $error("status read lost fault sent bit");

    link_flag_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        link_up |=> flag_q[BKAN_FLAG_LINK] [*2] or
            (flag_q[BKAN_FLAG_LINK] ##1 (!flag_q[BKAN_FLAG_LINK] && $past(st_read_done)))
        )
        else $error("link up flag dropped without a read");

    status_levels_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (first_acc && hit_st && !pwrite) |=>
            prdata[BKAN_ST_READY_LO +: BKAN_READY_W] == $past(link_ready) &&
            prdata[BKAN_ST_COMPLETE] == $past(an_complete) &&
            prdata[BKAN_ST_ABILITY] == AN_ABILITY)
        else $error("status levels misreported");

    // the edge that releases reset still loads reset values, so checks of
    // registered outputs start one edge later
    override_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(presetn) && !ovr) |=> advertised_technology_set == DEF_TECH &&
            advertised_fec_bits == DEF_FEC && advertised_pause_bits == DEF_PAUSE)
        else $error("override fields acted while disabled");

    override_use_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ovr |=> advertised_technology_set == $past(low_q[BKAN_TECH_LO +: BKAN_TECH_W]) &&
            advertised_fec_bits == $past(low_q[BKAN_FEC_LO +: BKAN_FEC_W]) &&
            advertised_pause_bits == $past(low_q[BKAN_PAUSE_LO +: BKAN_PAUSE_W]))
        else $error("override fields not applied");

    prbs_from_sm_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> tx_page[BKAN_PG_PRBS] == $past(sm_prbs))
        else $error("prbs bit not taken from machine");

    user_page_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctl_q[BKAN_CTL_BASE_PAGE] |=>
            tx_page[BKAN_PG_NONCE_LO +: BKAN_HI_NONCE_W + BKAN_HI_TECH_W] ==
            $past(high_q[BKAN_HI_NONCE_W + BKAN_HI_TECH_W - 1:0]) &&
            tx_page[BKAN_PG_ECHO_LO-1:0] == $past(low_q[BKAN_PG_ECHO_LO-1:0]) &&
            tx_page[BKAN_PG_ACK] == $past(sm_ack) &&
            tx_page[BKAN_PG_ECHO_LO +: BKAN_PG_ECHO_W] == $past(sm_echo_nonce))
        else $error("user base page not mapped onto page");

    sm_page_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(presetn) && !ctl_q[BKAN_CTL_BASE_PAGE]) |=>
            tx_page[BKAN_PG_PRBS-1:0] == $past(sm_page[BKAN_PG_PRBS-1:0]))
        else $error("machine page not passed while user pages off");

    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (first_acc && !mapped) |=> pready && pslverr ##1 !pready)
        else $error("unmapped access not refused");
endmodule : bkan_status_pages

/* File: tb/bkan_engine_model.sv */
// far-side negotiation engine: machine-built page, ack, echo and prbs.
// assumes bench clock and reset; fields change every cycle.
`timescale 1ns/1ps
module bkan_engine_model
    import bkan_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    output logic [BKAN_PAGE_W-1:0] sm_page,
    output logic sm_ack,
    output logic [BKAN_PG_ECHO_W-1:0] sm_echo_nonce,
    output logic sm_prbs
);
    logic [63:0] lfsr_q;
    // a moving pattern, so a stale copy in the page shows up at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lfsr_q <= 64'h0000_0000_0000_51ed;
        else
            lfsr_q <= {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
    end
    assign sm_page = lfsr_q[49:0];
    assign sm_ack = lfsr_q[50];
    assign sm_echo_nonce = lfsr_q[55:51];
    assign sm_prbs = lfsr_q[63];
endmodule : bkan_engine_model

/* File: tb/bkan_status_pages_tb.sv */
// self-checking bench for the negotiation status and page registers.
// assumes one pclk domain; the bench plays software and status sources.
`timescale 1ns/1ps
module bkan_status_pages_tb
    import bkan_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, user_base_page_en, override_en, sm_ack, sm_prbs;
    logic page_rx_evt = 0, an_complete = 0, rf_sent_evt = 0, rx_idle = 0, link_up = 0;
    logic lp_an_ability = 0, fec_negotiated = 0, seq_failure = 0;
    logic [5:0] link_ready = '0, adv_tech;
    logic [1:0] adv_fec;
    logic [2:0] adv_pause;
    logic [4:0] sm_echo_nonce;
    logic [49:0] sm_page, tx_page;
    int errors = 0, tests_run = 0, cycles = 0;
    logic [31:0] rng = 32'd20975, m_ctl = '0, m_low = '0, m_high = '0, r;
    bit m_pg = 0, m_rf = 0, m_lk = 0;

    always #4 pclk = ~pclk;

    bkan_engine_model peer (.pclk(pclk), .presetn(presetn), .sm_page(sm_page),
        .sm_ack(sm_ack), .sm_echo_nonce(sm_echo_nonce), .sm_prbs(sm_prbs));

    bkan_status_pages #(.DEF_TECH(6'h04)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .page_rx_evt(page_rx_evt), .an_complete(an_complete),
        .rf_sent_evt(rf_sent_evt), .rx_idle(rx_idle), .link_up(link_up),
        .lp_an_ability(lp_an_ability), .fec_negotiated(fec_negotiated),
        .seq_failure(seq_failure), .link_ready(link_ready), .sm_page(sm_page),
        .sm_ack(sm_ack), .sm_echo_nonce(sm_echo_nonce), .sm_prbs(sm_prbs),
        .tx_page(tx_page), .user_base_page_en(user_base_page_en),
        .override_en(override_en), .advertised_technology_set(adv_tech),
        .advertised_fec_bits(adv_fec), .advertised_pause_bits(adv_pause));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ev pulses a page event so that it lands on the clear edge of a read
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input bit ev, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            page_rx_evt <= ev && n == 0;
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk("pready", 1, 0);
    endtask : apb

    task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp,
                        input bit ev);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, ev, rd, e);
        chk(what, exp, rd);
        chk("pslverr", a == 16'h0100, e);
    endtask : rchk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, 1'b0, rd, e);
        chk("wr_err", 0, e);
    endtask : wr

    task automatic pg_chk();
        logic [49:0] e;
        @(posedge pclk);
        #1;
        e = sm_page;
        if (m_ctl[1])
        begin
            e[15:0] = m_low[15:0];
            e[14] = sm_ack;
            e[9:5] = sm_echo_nonce;
            e[20:16] = m_high[4:0];
            e[45:21] = m_high[29:5];
        end
        e[49] = sm_prbs;
        @(posedge pclk);
        #1;
        chk("tx_page", e, tx_page);
    endtask : pg_chk

    function automatic logic [31:0] st_exp();
        return {14'h0, link_ready, 2'b00, seq_failure, fec_negotiated, lp_an_ability,
                m_lk, 1'b1, rx_idle, m_rf, an_complete, m_pg, 1'b0};
    endfunction : st_exp

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctl", BKAN_ADDR_CONTROL, 32'h0, 0);
        rchk("low", BKAN_ADDR_PAGE_LOW, 32'h0, 0);
        rchk("high", BKAN_ADDR_PAGE_HIGH, 32'h0, 0);
        rchk("unmapped", 16'h0100, 32'h0, 0);
        for (int i = 0; i < 8; i++)
        begin
            m_low = xs();
            m_high = xs();
            m_ctl = (xs() & ~32'h22) | (i[0] ? 32'h2 : 32'h0) | (i[1] ? 32'h20 : 32'h0);
            wr(BKAN_ADDR_PAGE_LOW, m_low);
            wr(BKAN_ADDR_PAGE_HIGH, m_high);
            wr(BKAN_ADDR_CONTROL, m_ctl);
            rchk("low", BKAN_ADDR_PAGE_LOW, m_low & BKAN_LOW_MASK, 0);
            rchk("high", BKAN_ADDR_PAGE_HIGH, m_high & BKAN_HIGH_MASK, 0);
            rchk("ctl", BKAN_ADDR_CONTROL, m_ctl & BKAN_CTL_MASK, 0);
            chk("ovr_en", m_ctl[5], override_en);
            chk("user_en", m_ctl[1], user_base_page_en);
            chk("tech", m_ctl[5] ? m_low[21:16] : 6'h04, adv_tech);
            chk("fec", m_ctl[5] ? m_low[25:24] : 2'h0, adv_fec);
            chk("pause", m_ctl[5] ? m_low[30:28] : 3'h0, adv_pause);
            repeat (3) pg_chk();
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            r = xs();
            {an_complete, rx_idle, link_up, lp_an_ability, fec_negotiated, seq_failure} <= r[5:0];
            link_ready <= (i < 6) ? 6'(1 << i) : 6'h0;
            rf_sent_evt <= r[6];
            page_rx_evt <= r[7];
            @(posedge pclk);
            rf_sent_evt <= 1'b0;
            page_rx_evt <= 1'b0;
            m_pg = m_pg | r[7];
            m_rf = m_rf | r[6];
            m_lk = m_lk | r[3];
            wr(BKAN_ADDR_STATUS, 32'hffff_ffff);
            rchk("status", BKAN_ADDR_STATUS, st_exp(), i[0]);
            m_pg = i[0];
            m_rf = 0;
            m_lk = link_up;
            rchk("status_again", BKAN_ADDR_STATUS, st_exp(), 0);
            m_pg = 0;
            m_lk = link_up;
        end
        final_report();
    end
endmodule : bkan_status_pages_tb
